// ==== core/amp_gain_mode_serial_control.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// gain and chip-state control for the upstream amplifier
// ============================================================================
// Summary of operation
// - shifted bits are taken only while the active-low select is held low for the word.
// - data is sampled on each rising shift clock edge, most significant bit first.
// - the rising edge of the select copies the shifted word into the storage latch.
// - the six low latched bits pick one of 64 attenuator steps of one decibel each.
// - transmission needs both the transmit gate pin and latched bit 7 high.
// - latched bit 6 selects +16dB high gain when one and 0dB low noise when zero.
// - low-noise transmit sits 16dB below high-power transmit for the same code.
// - both chip-state bits zero give software shutdown while the gain code is kept.
// - a low transmit gate pin forces transmit disabled unless software or hard shutdown applies.
// - a low power-down pin disables everything and wipes the control latch.
// - transmit disabled switches the output stage to common-mode drive.
module amp_gain_mode_serial_control (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic shift_clk,
  input wire logic select_n,
  input wire logic serial_data,
  input wire logic transmit_gate_pin,
  input wire logic power_down_n,
  output logic [2:0] amp_state,
  output logic transmit_enable,
  output logic gain_mode_select,
  output logic chip_state_high_bit,
  output logic [amp_ctrl_pkg::GAIN_W-1:0] attenuator_gain_code,
  output logic [amp_ctrl_pkg::GAIN_W-1:0] attenuation_db,
  output logic [amp_ctrl_pkg::PA_GAIN_W-1:0] amp_gain_db,
  output logic common_mode_drive,
  output logic analog_on,
  output logic word_valid,
  output logic word_loaded
);

  // ==========================================================================
  // decoding
  // ==========================================================================

  // chip state from the effective pin level and the latched state bits
  function automatic amp_ctrl_pkg::amp_state_type decode_state(
    input logic pd_n,
    input logic gate,
    input logic hi_bit,
    input logic mode_bit
  );
    amp_ctrl_pkg::amp_state_type st;
    st = amp_ctrl_pkg::HARD_SHUTDOWN;
    if (!pd_n) begin
      st = amp_ctrl_pkg::HARD_SHUTDOWN;
    end else if ({hi_bit, mode_bit} == amp_ctrl_pkg::CHIP_STATE_SOFT_OFF) begin
      st = amp_ctrl_pkg::SOFT_SHUTDOWN;
    end else if (!(gate && hi_bit)) begin
      st = amp_ctrl_pkg::TX_DISABLED;
    end else if (mode_bit) begin
      st = amp_ctrl_pkg::HIGH_POWER_TX;
    end else begin
      st = amp_ctrl_pkg::LOW_NOISE_TX;
    end
    return st;
  endfunction : decode_state

  // amplifier gain that a state uses; off states report the low setting
  function automatic logic [amp_ctrl_pkg::PA_GAIN_W-1:0] state_gain(
    input amp_ctrl_pkg::amp_state_type st
  );
    logic [amp_ctrl_pkg::PA_GAIN_W-1:0] g;
    g = amp_ctrl_pkg::PA_LOW_NOISE_DB;
    if (st == amp_ctrl_pkg::HIGH_POWER_TX) begin
      g = amp_ctrl_pkg::PA_HIGH_GAIN_DB;
    end
    return g;
  endfunction : state_gain

  // ==========================================================================
  // reset release
  // ==========================================================================
  logic [amp_ctrl_pkg::SYNC_STAGES-1:0] rst_sync_reg;
  logic rst_n;

  // async assert, release after two clean edges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[amp_ctrl_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[amp_ctrl_pkg::SYNC_STAGES-1];

  // ==========================================================================
  // shift clock domain
  // ==========================================================================
  serial_word_if word_bus ();

  serial_shifter shifter_inst (
    .shift_clk(shift_clk),
    .power_down_n(power_down_n),
    .select_n(select_n),
    .serial_data(serial_data),
    .word_bus(word_bus.link)
  );

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  // each pin passes two flops; only the second stage is read
  logic [1:0] select_meta_reg;
  logic [1:0] gate_meta_reg;
  logic [1:0] pd_meta_reg;
  logic select_prev_reg;
  logic select_sync;
  logic gate_sync;
  logic pd_sync;
  logic select_rise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      select_meta_reg <= 2'h3;
    end else begin
      select_meta_reg <= {select_meta_reg[0], select_n};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_meta_reg <= 2'h0;
    end else begin
      gate_meta_reg <= {gate_meta_reg[0], transmit_gate_pin};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_meta_reg <= 2'h0;
    end else begin
      pd_meta_reg <= {pd_meta_reg[0], power_down_n};
    end
  end

  assign select_sync = select_meta_reg[1];
  assign gate_sync = gate_meta_reg[1];
  assign pd_sync = pd_meta_reg[1];

  // edge history, one more flop past the synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      select_prev_reg <= 1'b1;
    end else begin
      select_prev_reg <= select_sync;
    end
  end

  // released select: shifting has stopped, so the word is quiet to sample
  assign select_rise = select_sync && !select_prev_reg;

  // ==========================================================================
  // storage latch
  // ==========================================================================
  logic [amp_ctrl_pkg::WORD_W-1:0] latch_reg;
  logic [amp_ctrl_pkg::WORD_W-1:0] latch_next;
  logic word_valid_reg;
  logic word_valid_next;

  // power-down wins over a load arriving in the same cycle
  always_comb begin
    latch_next = latch_reg;
    word_valid_next = word_valid_reg;
    if (!pd_sync) begin
      latch_next = amp_ctrl_pkg::WORD_RESET;
      word_valid_next = 1'b0;
    end else if (select_rise && word_bus.shift_busy) begin
      latch_next = word_bus.shift_word;
      word_valid_next = 1'b1;
    end
  end

  // only this latch steers the outputs, never the live shift word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= amp_ctrl_pkg::WORD_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid_reg <= 1'b0;
    end else begin
      word_valid_reg <= word_valid_next;
    end
  end

  // one-cycle pulse per accepted word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_loaded <= 1'b0;
    end else begin
      word_loaded <= pd_sync && select_rise && word_bus.shift_busy;
    end
  end

  // ==========================================================================
  // chip state decode
  // ==========================================================================
  amp_ctrl_pkg::amp_state_type state_next;
  logic hi_bit;
  logic mode_bit;
  logic [amp_ctrl_pkg::GAIN_W-1:0] code_bits;

  assign hi_bit = latch_next[amp_ctrl_pkg::CHIP_STATE_HI_POS];
  assign mode_bit = latch_next[amp_ctrl_pkg::GAIN_MODE_POS];
  assign code_bits = latch_next[amp_ctrl_pkg::GAIN_CODE_LSB +: amp_ctrl_pkg::GAIN_W];

  assign state_next = decode_state(pd_sync, gate_sync, hi_bit, mode_bit);

  // ==========================================================================
  // registered outputs
  // ==========================================================================
  // state and enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_state <= 3'(amp_ctrl_pkg::HARD_SHUTDOWN);
      transmit_enable <= 1'b0;
    end else begin
      amp_state <= 3'(state_next);
      transmit_enable <= pd_sync && gate_sync && hi_bit;
    end
  end

  // raw latched bits, visible even while the chain is off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_state_high_bit <= 1'b0;
      gain_mode_select <= 1'b0;
      attenuator_gain_code <= amp_ctrl_pkg::GAIN_CODE_RESET;
    end else begin
      chip_state_high_bit <= hi_bit;
      gain_mode_select <= mode_bit;
      attenuator_gain_code <= code_bits;
    end
  end

  // attenuation: code step times one decibel, 64 settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      attenuation_db <= amp_ctrl_pkg::GAIN_CODE_RESET;
    end else begin
      attenuation_db <= amp_ctrl_pkg::GAIN_W'(code_bits * amp_ctrl_pkg::STEP_DB);
    end
  end

  // amplifier gain: 16dB apart between the two transmit states
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_gain_db <= amp_ctrl_pkg::PA_LOW_NOISE_DB;
    end else begin
      amp_gain_db <= state_gain(state_next);
    end
  end

  // output stage drive: common mode while disabled, analog off when shut down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      common_mode_drive <= 1'b0;
      analog_on <= 1'b0;
    end else begin
      common_mode_drive <= (state_next == amp_ctrl_pkg::TX_DISABLED);
      analog_on <= (state_next != amp_ctrl_pkg::SOFT_SHUTDOWN) &&
                   (state_next != amp_ctrl_pkg::HARD_SHUTDOWN);
    end
  end

  // flag that a frame of at least one bit has landed since the last power-down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid <= 1'b0;
    end else begin
      word_valid <= word_valid_next;
    end
  end

endmodule : amp_gain_mode_serial_control
`default_nettype wire

// ==== core/amp_ctrl_pkg.sv ====
// ============================================================================
// constants shared by the serial front end and the control core
// ============================================================================
package amp_ctrl_pkg;

  // control word layout
  localparam int WORD_W = 8;
  localparam int GAIN_W = 6;
  localparam int CHIP_STATE_HI_POS = 7;
  localparam int GAIN_MODE_POS = 6;
  localparam int GAIN_CODE_LSB = 0;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_CODE_RESET = 6'h00;

  // attenuator: 64 steps of nominally one decibel
  localparam int GAIN_STEPS = 64;
  localparam int STEP_DB = 1;

  // output amplifier gain settings in dB
  localparam int PA_GAIN_W = 5;
  localparam logic [PA_GAIN_W-1:0] PA_HIGH_GAIN_DB = 5'h10;
  localparam logic [PA_GAIN_W-1:0] PA_LOW_NOISE_DB = 5'h00;

  // chip state field values (bit 7, bit 6)
  localparam logic [1:0] CHIP_STATE_SOFT_OFF = 2'h0;

  // synchroniser depth and reset release depth
  localparam int SYNC_STAGES = 2;

  // operating state of the amplifier chain
  typedef enum logic [2:0] {
    HARD_SHUTDOWN,
    SOFT_SHUTDOWN,
    TX_DISABLED,
    LOW_NOISE_TX,
    HIGH_POWER_TX
  } amp_state_type;

endpackage : amp_ctrl_pkg

// ==== core/serial_word_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// carrier between the shift-clock front end and the system-clock core
// ============================================================================
interface serial_word_if;
  logic [amp_ctrl_pkg::WORD_W-1:0] shift_word;
  logic shift_busy;

  modport link (output shift_word, output shift_busy);
  modport core (input shift_word, input shift_busy);
endinterface : serial_word_if
`default_nettype wire

// ==== core/serial_shifter.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// shift register on the serial shift clock
// ============================================================================
module serial_shifter (
  input wire logic shift_clk,
  input wire logic power_down_n,
  input wire logic select_n,
  input wire logic serial_data,
  serial_word_if.link word_bus
);

  logic [amp_ctrl_pkg::WORD_W-1:0] shift_reg;
  logic shift_busy_reg;

  // msb first, sampled on rising shift clock, only while selected
  // power-down wipes the partial word without needing a clock edge
  always_ff @(posedge shift_clk or negedge power_down_n) begin
    if (!power_down_n) begin
      shift_reg <= amp_ctrl_pkg::WORD_RESET;
    end else if (!select_n) begin
      shift_reg <= {shift_reg[amp_ctrl_pkg::WORD_W-2:0], serial_data};
    end
  end

  // marks that at least one bit went in during the current frame
  always_ff @(posedge shift_clk or negedge power_down_n) begin
    if (!power_down_n) begin
      shift_busy_reg <= 1'b0;
    end else begin
      shift_busy_reg <= !select_n;
    end
  end

  assign word_bus.shift_word = shift_reg;
  assign word_bus.shift_busy = shift_busy_reg;

endmodule : serial_shifter
`default_nettype wire

// ==== bench/amp_ctrl_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// port checks on the amplifier control block
// ============================================================================
module amp_ctrl_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic shift_clk,
  input wire logic select_n,
  input wire logic serial_data,
  input wire logic transmit_gate_pin,
  input wire logic power_down_n,
  input wire logic [2:0] amp_state,
  input wire logic transmit_enable,
  input wire logic gain_mode_select,
  input wire logic chip_state_high_bit,
  input wire logic [amp_ctrl_pkg::GAIN_W-1:0] attenuator_gain_code,
  input wire logic [amp_ctrl_pkg::GAIN_W-1:0] attenuation_db,
  input wire logic [amp_ctrl_pkg::PA_GAIN_W-1:0] amp_gain_db,
  input wire logic common_mode_drive,
  input wire logic analog_on,
  input wire logic word_valid,
  input wire logic word_loaded
);
  // all checks live on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_gain;
    amp_gain_db == ((amp_state == 3'h4) ? 5'h10 : 5'h00);
  endproperty
  a_gain: assert property (p_gain) else $error("amp gain off");
  property p_att;
    attenuation_db == attenuator_gain_code;
  endproperty
  a_att: assert property (p_att) else $error("attenuation off");
  property p_cm;
    common_mode_drive == (amp_state == 3'h2);
  endproperty
  a_cm: assert property (p_cm) else $error("common mode off");
  property p_tx;
    transmit_enable == (chip_state_high_bit && amp_state > 3'h2);
  endproperty
  a_tx: assert property (p_tx) else $error("tx enable off");
  // gate pin crosses a synchroniser, so allow it time
  property p_gate;
    !transmit_gate_pin [*4] |=> !transmit_enable && amp_state < 3'h3;
  endproperty
  a_gate: assert property (p_gate) else $error("gate ignored");
  property p_soft;
    amp_state == 3'h1 |-> !analog_on && !chip_state_high_bit && !gain_mode_select;
  endproperty
  a_soft: assert property (p_soft) else $error("soft off wrong");
  property p_pd;
    !power_down_n [*4] |=> amp_state == 3'h0 && !word_valid && attenuator_gain_code == 6'h00;
  endproperty
  a_pd: assert property (p_pd) else $error("power down kept");
  property p_load;
    word_loaded |=> !word_loaded && word_valid;
  endproperty
  a_load: assert property (p_load) else $error("load pulse wrong");
  property p_sel;
    word_loaded |-> select_n;
  endproperty
  a_sel: assert property (p_sel) else $error("load in frame");

  c_load: cover property (word_loaded);
  c_hp: cover property (amp_state == 3'h4);
  c_soft: cover property (amp_state == 3'h1);
  c_dis: cover property (amp_state == 3'h2 && common_mode_drive);
endmodule : amp_ctrl_checker

bind amp_gain_mode_serial_control amp_ctrl_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .shift_clk(shift_clk), .select_n(select_n), .serial_data(serial_data),
  .transmit_gate_pin(transmit_gate_pin), .power_down_n(power_down_n), .amp_state(amp_state),
  .transmit_enable(transmit_enable), .gain_mode_select(gain_mode_select),
  .chip_state_high_bit(chip_state_high_bit), .attenuator_gain_code(attenuator_gain_code),
  .attenuation_db(attenuation_db), .amp_gain_db(amp_gain_db),
  .common_mode_drive(common_mode_drive), .analog_on(analog_on), .word_valid(word_valid),
  .word_loaded(word_loaded));
`default_nettype wire

// ==== bench/serial_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// serial controller: link clock runs only inside frames
// ============================================================================
module serial_ctrl_model (
  output logic shift_clk,
  output logic select_n,
  output logic serial_data
);
  // idle bus
  initial begin
    shift_clk = 1'b0;
    select_n = 1'b1;
    serial_data = 1'b0;
  end
  // data set while clock low, taken at the rise
  task bit_out(input logic b);
    serial_data = b;
    #24 shift_clk = 1'b1;
    #24 shift_clk = 1'b0;
  endtask : bit_out
  // select stays low over the whole word
  task send8(input logic [7:0] w);
    select_n = 1'b0;
    #24;
    for (int i = 7; i >= 0; i--) bit_out(w[i]);
    close_frame();
  endtask : send8
  task send16(input logic [15:0] w);
    select_n = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) bit_out(w[i]);
    close_frame();
  endtask : send16
  // released data flips so a stale bit never looks valid
  task close_frame();
    #24 select_n = 1'b1;
    serial_data = ~serial_data;
  endtask : close_frame
endmodule : serial_ctrl_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// bench top
// ============================================================================
module tb_top;
  typedef struct packed {
    logic [7:0] w;
    logic g;
    logic [2:0] st;
    logic [4:0] db;
  } row_type;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic transmit_gate_pin = 1'b1;
  logic power_down_n = 1'b1;
  logic shift_clk, select_n, serial_data;
  logic [2:0] amp_state;
  logic transmit_enable, gain_mode_select, chip_state_high_bit;
  logic [amp_ctrl_pkg::GAIN_W-1:0] attenuator_gain_code, attenuation_db;
  logic [amp_ctrl_pkg::PA_GAIN_W-1:0] amp_gain_db;
  logic common_mode_drive, analog_on, word_valid, word_loaded;
  int n_fail = 0;
  int total_checks = 0;
  // word, gate pin, state, amp gain; high power picked where bits 7 and 6 are set and the gate pin is high
  row_type rows [7] = '{'{8'hc5, 1'b1, 3'h4, 5'h10}, '{8'h85, 1'b1, 3'h3, 5'h00},
    '{8'h7f, 1'b1, 3'h2, 5'h00}, '{8'hff, 1'b0, 3'h2, 5'h00}, '{8'h3f, 1'b0, 3'h1, 5'h00},
    '{8'h2a, 1'b1, 3'h1, 5'h00}, '{8'hc0, 1'b1, 3'h4, 5'h10}};

  always #5 sys_clk = ~sys_clk;

  serial_ctrl_model m (.shift_clk(shift_clk), .select_n(select_n), .serial_data(serial_data));
  amp_gain_mode_serial_control dut (.sys_clk(sys_clk), .arst_n(arst_n), .shift_clk(shift_clk),
    .select_n(select_n), .serial_data(serial_data), .transmit_gate_pin(transmit_gate_pin),
    .power_down_n(power_down_n), .amp_state(amp_state), .transmit_enable(transmit_enable),
    .gain_mode_select(gain_mode_select), .chip_state_high_bit(chip_state_high_bit),
    .attenuator_gain_code(attenuator_gain_code), .attenuation_db(attenuation_db),
    .amp_gain_db(amp_gain_db), .common_mode_drive(common_mode_drive), .analog_on(analog_on),
    .word_valid(word_valid), .word_loaded(word_loaded));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task stop_test();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // bounded wait for the load pulse, then a gap before the next frame
  task automatic wait_load();
    int k;
    k = 0;
    while (word_loaded !== 1'b1 && k < 60) begin
      @(negedge sys_clk);
      k++;
    end
    // judged on the pulse itself, so a pulse on the last try still passes
    if (word_loaded !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    repeat (6) @(negedge sys_clk);
  endtask : wait_load

  // table first, then hand cases
  initial begin
    repeat (10) @(negedge sys_clk);
    chk(amp_state, 3'h0);
    chk(word_valid, 1'b0);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    foreach (rows[i]) begin
      transmit_gate_pin = rows[i].g;
      m.send8(rows[i].w);
      wait_load();
      chk(amp_state, rows[i].st);
      chk(attenuator_gain_code, rows[i].w[5:0]);
      chk(amp_gain_db, rows[i].db);
      chk(common_mode_drive, rows[i].st == 3'h2);
      chk(word_valid, 1'b1);
      chk(chip_state_high_bit, rows[i].w[7]);
      chk(gain_mode_select, rows[i].w[6]);
      chk(attenuation_db, rows[i].w[5:0]);
      chk(transmit_enable, rows[i].g && rows[i].w[7]);
      chk(analog_on, rows[i].st > 3'h1);
      chk(word_loaded, 1'b0);
    end
    // sixteen bits in one frame: only the last eight count
    m.send16(16'h3ac6);
    wait_load();
    chk(amp_state, 3'h4);
    chk(attenuator_gain_code, 6'h06);
    // gate pin alone, no new word
    transmit_gate_pin = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(amp_state, 3'h2);
    chk(transmit_enable, 1'b0);
    transmit_gate_pin = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(transmit_enable, 1'b1);
    // power down wipes the latch; a fresh word is needed afterwards
    power_down_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(amp_state, 3'h0);
    chk(word_valid, 1'b0);
    power_down_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(amp_state, 3'h1);
    chk(attenuator_gain_code, 6'h00);
    m.send8(8'hc6);
    wait_load();
    chk(amp_state, 3'h4);
    // mid-run reset: outputs drop at once, latch comes back empty
    arst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(amp_state, 3'h0);
    chk(transmit_enable, 1'b0);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(amp_state, 3'h1);
    chk(word_valid, 1'b0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
